// [logic/fpp_defs.vh]
/*
 fpp_defs.vh: constants for the fuse PROM read and burn controller.
 assumes a 100 MHz clock; included by bare name by the design files.
*/
`ifndef FPP_DEFS_VH
`define FPP_DEFS_VH

`define FPP_CLK_MHZ 100
`define FPP_WORDS 32
`define FPP_ADDR_W 5
`define FPP_DATA_W 8
`define FPP_BIT_IDX_W 3
// times in nanoseconds, as printed
`define FPP_PULSE_NS 7500
`define FPP_SENSE_DELAY_NS 700
`define FPP_SENSE_GAP_NS 10000
`define FPP_ADDR_GUARD_NS 10000
// least times round up to whole cycles
`define FPP_CYC_UP(ns) (((ns) * `FPP_CLK_MHZ + 999) / 1000)
`define FPP_PULSE_CYC `FPP_CYC_UP(`FPP_PULSE_NS)
`define FPP_SENSE_DELAY_CYC `FPP_CYC_UP(`FPP_SENSE_DELAY_NS)
`define FPP_SENSE_GAP_CYC `FPP_CYC_UP(`FPP_SENSE_GAP_NS)
`define FPP_ADDR_GUARD_CYC `FPP_CYC_UP(`FPP_ADDR_GUARD_NS)
`define FPP_EXTRA_PULSES 4
`define FPP_READ_SETTLE_CYC 4
`define FPP_CNT_W 12
`define FPP_MAX_PULSES_DEF 100

`endif

// [logic/fpp_delay_timer.v]
/*
 fpp_delay_timer.v: loadable down counter giving a one-cycle done pulse.
 assumes the loader keeps start low while the count runs.
*/
`timescale 1ns/1ps
`include "fpp_defs.vh"

module fpp_delay_timer #(
   parameter W = `FPP_CNT_W
) (
   input wire clk,
   input wire rst_n,
   input wire start,
   input wire [W-1:0] load,
   output reg done
);
   reg [W-1:0] cnt_reg;
   reg busy_reg;

   always @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= {W{1'b0}};
         busy_reg <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_reg <= load;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
               busy_reg <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// [logic/fpp_prom_ctrl.v]
/*
 fpp_prom_ctrl.v: host controller for a 32x8 fuse PROM: reads words
 and burns single bits with pulse trains and sense readings.
 assumes external pulse and sense drivers act on the enables given here,
 and a comparator reporting whether the sensed output meets the limit.
*/
`timescale 1ns/1ps
`include "fpp_defs.vh"

module fpp_prom_ctrl #(
   parameter AW = `FPP_ADDR_W,
   parameter DW = `FPP_DATA_W,
   parameter MAX_PULSES = `FPP_MAX_PULSES_DEF
) (
   input wire clk,
   input wire rst_n,
   input wire readReq,
   input wire burnReq,
   input wire [AW-1:0] reqWord,
   input wire [`FPP_BIT_IDX_W-1:0] reqBit,
   input wire [DW-1:0] dataLinesIn,
   input wire senseOk,
   output reg [AW-1:0] wordSelectLines,
   output reg selectN,
   output reg [DW-1:0] pulseEn,
   output reg senseEn,
   output reg busy,
   output reg done,
   output reg fail,
   output reg [DW-1:0] readData
);
   localparam S_IDLE = 4'h0;
   localparam S_RSETUP = 4'h1;
   localparam S_RSAMPLE = 4'h2;
   localparam S_PGUARD = 4'h3;
   localparam S_PULSE = 4'h4;
   localparam S_SDELAY = 4'h5;
   localparam S_SENSE1 = 4'h6;
   localparam S_SGAP = 4'h7;
   localparam S_SENSE2 = 4'h8;
   localparam S_XPULSE = 4'h9;
   localparam S_XGAP = 4'ha;
   localparam S_POST = 4'hb;
   localparam S_FINISH = 4'hc;

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [DW-1:0] dataSync1_reg;
   reg [DW-1:0] dataSync2_reg;
   reg okSync1_reg;
   reg okSync2_reg;
   reg [15:0] pulseCnt_reg;
   reg [2:0] extraCnt_reg;
   reg [`FPP_BIT_IDX_W-1:0] bit_reg;
   reg failed_reg;
   reg tStart;
   // whole-integer load values, cut to the timer width at the port
   reg [31:0] tLoad;
   wire tDone;

   fpp_delay_timer #(.W(`FPP_CNT_W)) timer (
      .clk(clk),
      .rst_n(rst_n),
      .start(tStart),
      .load(tLoad[`FPP_CNT_W-1:0]),
      .done(tDone)
   );

   // pins and comparator are off-domain: two stages before use
   always @(posedge clk) begin
      if (!rst_n) begin
         dataSync1_reg <= {DW{1'b0}};
         dataSync2_reg <= {DW{1'b0}};
         okSync1_reg <= 1'b0;
         okSync2_reg <= 1'b0;
      end else begin
         dataSync1_reg <= dataLinesIn;
         dataSync2_reg <= dataSync1_reg;
         okSync1_reg <= senseOk;
         okSync2_reg <= okSync1_reg;
      end
   end

   always @* begin
      state_next = state_reg;
      tStart = 1'b0;
      tLoad = 32'h00000000;
      case (state_reg)
         S_IDLE: begin
            if (readReq) begin
               state_next = S_RSETUP;
               tStart = 1'b1;
               tLoad = `FPP_READ_SETTLE_CYC;
            end else if (burnReq) begin
               state_next = S_PGUARD;
               tStart = 1'b1;
               tLoad = `FPP_ADDR_GUARD_CYC;
            end
         end
         S_RSETUP: if (tDone) state_next = S_RSAMPLE;
         S_RSAMPLE: state_next = S_FINISH;
         S_PGUARD: begin
            if (tDone) begin
               state_next = S_PULSE;
               tStart = 1'b1;
               tLoad = `FPP_PULSE_CYC;
            end
         end
         S_PULSE: begin
            if (tDone) begin
               state_next = S_SDELAY;
               tStart = 1'b1;
               tLoad = `FPP_SENSE_DELAY_CYC;
            end
         end
         S_SDELAY: if (tDone) state_next = S_SENSE1;
         S_SENSE1: begin
            tStart = 1'b1;
            if (okSync2_reg) begin
               state_next = S_SGAP;
               tLoad = `FPP_SENSE_GAP_CYC;
            end else if (pulseCnt_reg >= MAX_PULSES) begin
               state_next = S_POST;
               tLoad = `FPP_ADDR_GUARD_CYC;
            end else begin
               state_next = S_PULSE;
               tLoad = `FPP_PULSE_CYC;
            end
         end
         S_SGAP: if (tDone) state_next = S_SENSE2;
         S_SENSE2: begin
            tStart = 1'b1;
            if (okSync2_reg) begin
               state_next = S_XPULSE;
               tLoad = `FPP_PULSE_CYC;
            end else begin
               state_next = S_PULSE;
               tLoad = `FPP_PULSE_CYC;
            end
         end
         S_XPULSE: begin
            if (tDone) begin
               state_next = S_XGAP;
               tStart = 1'b1;
               tLoad = `FPP_SENSE_DELAY_CYC;
            end
         end
         S_XGAP: begin
            if (tDone) begin
               tStart = 1'b1;
               if (extraCnt_reg == `FPP_EXTRA_PULSES - 1) begin
                  state_next = S_POST;
                  tLoad = `FPP_ADDR_GUARD_CYC;
               end else begin
                  state_next = S_XPULSE;
                  tLoad = `FPP_PULSE_CYC;
               end
            end
         end
         S_POST: if (tDone) state_next = S_FINISH;
         S_FINISH: state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= S_IDLE;
         wordSelectLines <= {AW{1'b0}};
         selectN <= 1'b1;
         pulseEn <= {DW{1'b0}};
         senseEn <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         fail <= 1'b0;
         readData <= {DW{1'b0}};
         pulseCnt_reg <= 16'h0000;
         extraCnt_reg <= 3'h0;
         bit_reg <= {`FPP_BIT_IDX_W{1'b0}};
         failed_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done <= 1'b0;
         busy <= (state_next != S_IDLE);
         if (state_reg == S_IDLE && readReq) begin
            wordSelectLines <= reqWord;
            selectN <= 1'b0;
         end else if (state_reg == S_IDLE && burnReq) begin
            selectN <= 1'b1;
            wordSelectLines <= reqWord;
            bit_reg <= reqBit;
            pulseCnt_reg <= 16'h0000;
            extraCnt_reg <= 3'h0;
            failed_reg <= 1'b0;
            senseEn <= 1'b0;
         end
         if (state_reg == S_RSAMPLE) begin
            readData <= dataSync2_reg;
            selectN <= 1'b1;
         end
         // sense current on from first pulse until train ends
         if (state_reg == S_PGUARD && tDone) senseEn <= 1'b1;
         if (state_next == S_PULSE || state_next == S_XPULSE)
            pulseEn <= {{(DW-1){1'b0}}, 1'b1} << bit_reg;
         else
            pulseEn <= {DW{1'b0}};
         if (state_reg == S_PULSE && tDone)
            pulseCnt_reg <= pulseCnt_reg + 16'h0001;
         if (state_reg == S_SENSE1 && !okSync2_reg &&
             pulseCnt_reg >= MAX_PULSES)
            failed_reg <= 1'b1;
         if (state_reg == S_XGAP && tDone)
            extraCnt_reg <= extraCnt_reg + 3'h1;
         // train over before the sense current goes
         if (state_next == S_POST) senseEn <= 1'b0;
         if (state_reg == S_FINISH) begin
            done <= 1'b1;
            fail <= failed_reg;
         end
      end
   end
endmodule

// [testbench/fpp_prom_chk.sv]
/* fpp_prom_chk: pin timing assertions for the PROM controller.
 assumes binding onto fpp_prom_ctrl, one clock domain. */
`timescale 1ns/1ps
module fpp_prom_chk #(parameter AW = 5, parameter DW = 8) (
   input wire clk,
   input wire rst_n,
   input wire readReq,
   input wire burnReq,
   input wire [AW-1:0] reqWord,
   input wire [AW-1:0] wordSelectLines,
   input wire selectN,
   input wire [DW-1:0] pulseEn,
   input wire senseEn,
   input wire busy,
   input wire done,
   input wire fail
);
   reg [11:0] chgCnt;
   reg [11:0] offCnt;
   reg [11:0] gapCnt;
   wire pulsing = |pulseEn;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // saturated at reset so the first address change is not flagged
   always @(posedge clk) begin
      if (!rst_n) begin
         chgCnt <= 12'hfff;
         offCnt <= 12'hfff;
         gapCnt <= 12'hfff;
      end else begin
         if (pulsing)
            gapCnt <= 12'h000;
         else if (gapCnt != 12'hfff)
            gapCnt <= gapCnt + 12'h001;
         if ($changed(wordSelectLines))
            chgCnt <= 12'h000;
         else if (chgCnt != 12'hfff)
            chgCnt <= chgCnt + 12'h001;
         if (senseEn)
            offCnt <= 12'h000;
         else if (offCnt != 12'hfff)
            offCnt <= offCnt + 12'h001;
      end
   end
   a_pulse_deselected: assert property (pulsing |-> selectN)
      else $error("pulse while selected");
   a_one_bit: assert property ($onehot0(pulseEn))
      else $error("more than one bit pulsed");
   a_sense_on_pulse: assert property (pulsing |-> senseEn)
      else $error("pulse without sense current");
   a_addr_steady: assert property (
      senseEn |-> $stable(wordSelectLines))
      else $error("address moved under sense");
   // chgCnt reads one less than the gap, offCnt the gap itself
   a_guard_before: assert property (
      $rose(senseEn) |-> chgCnt >= 12'h3e7)
      else $error("sense too soon after address");
   a_guard_after: assert property (
      $changed(wordSelectLines) |-> offCnt >= 12'h3e8)
      else $error("address too soon after sense");
   a_train_first: assert property (
      $fell(senseEn) |-> $past(pulseEn) == 8'h00)
      else $error("sense dropped inside train");
   a_pulse_gap: assert property ($fell(pulsing) |=> !pulsing [*8])
      else $error("no sense gap after pulse");
   a_sense_delay: assert property (
      $rose(pulsing) |-> gapCnt >= 12'h046)
      else $error("pulses closer than the sense delay");
   a_read_take: assert property (
      !busy && readReq |=> busy && !selectN)
      else $error("read not started");
   a_burn_take: assert property (
      !busy && burnReq && !readReq |=> busy && selectN)
      else $error("burn not started deselected");
   a_burn_addr: assert property (
      !busy && burnReq && !readReq |=> wordSelectLines == $past(reqWord))
      else $error("burn word not driven");
   cover property (done && fail);
   cover property ($rose(senseEn));
   cover property ($fell(senseEn));
   cover property (!busy && readReq);
endmodule
bind fpp_prom_ctrl fpp_prom_chk #(.AW(AW), .DW(DW)) chk_u (.clk(clk),
   .rst_n(rst_n), .readReq(readReq), .burnReq(burnReq), .busy(busy),
   .reqWord(reqWord),
   .wordSelectLines(wordSelectLines), .selectN(selectN), .fail(fail),
   .pulseEn(pulseEn), .senseEn(senseEn), .done(done));

// [testbench/fpp_prom_model.sv]
/* fpp_prom_model: 32x8 fuse PROM; a fuse opens on its second pulse,
 except one stuck fuse that never opens.
 assumes pull-ups on the data lines. */
`timescale 1ns/1ps
module fpp_prom_model #(
   parameter [4:0] STUCK_WORD = 5'h1e,
   parameter [2:0] STUCK_BIT = 3'h3
) (
   input wire clk,
   input wire [4:0] wordSelectLines,
   input wire selectN,
   input wire [7:0] pulseEn,
   input wire senseEn,
   output wire [7:0] dataLines,
   output wire senseOk
);
   reg [7:0] mem [0:31];
   reg [7:0] lastMask = 8'h00;
   reg [7:0] prevPulse = 8'h00;
   integer nPulse = 0;
   integer i;
   // lets the bench reach the give-up path of the burn
   wire [7:0] stuckMask = (wordSelectLines == STUCK_WORD) ?
      (8'h01 << STUCK_BIT) : 8'h00;
   initial for (i = 0; i < 32; i = i + 1) mem[i] = 8'h00;
   always @(posedge clk) begin
      prevPulse <= pulseEn;
      if (pulseEn != 8'h00)
         lastMask <= pulseEn;
      if (!senseEn)
         nPulse <= 0;
      else if (prevPulse != 8'h00 && pulseEn == 8'h00) begin
         nPulse <= nPulse + 1;
         if (nPulse >= 1)
            mem[wordSelectLines] <= mem[wordSelectLines] |
               (prevPulse & ~stuckMask);
      end
   end
   assign senseOk = senseEn && pulseEn == 8'h00 &&
      (mem[wordSelectLines] & lastMask) != 8'h00;
   assign dataLines = selectN ? 8'hff : mem[wordSelectLines];
endmodule

// [testbench/fpp_prom_ctrl_tb.sv]
/* fpp_prom_ctrl_tb: random burns and readback against the PROM model.
 assumes 100 MHz clock, short pulse cap. */
`timescale 1ns/1ps
module fpp_prom_ctrl_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg readReq = 1'b0;
   reg burnReq = 1'b0;
   reg [4:0] reqWord = 5'h00;
   reg [2:0] reqBit = 3'h0;
   reg [7:0] shadow [0:31];
   reg [31:0] seed = 32'h19;
   localparam [4:0] STUCK_W = 5'h1e;
   localparam [2:0] STUCK_B = 3'h3;
   wire [4:0] wordSelectLines;
   wire selectN, senseEn, busy, done, fail, senseOk;
   wire [7:0] pulseEn, readData, dataLines;
   integer n_fail = 0;
   integer tests_run = 0;
   integer k;
   always #5 clk = ~clk;
   fpp_prom_ctrl #(.MAX_PULSES(3)) dut_u (.clk(clk), .rst_n(rst_n),
      .readReq(readReq), .burnReq(burnReq), .reqWord(reqWord),
      .reqBit(reqBit), .dataLinesIn(dataLines), .senseOk(senseOk),
      .wordSelectLines(wordSelectLines), .selectN(selectN),
      .pulseEn(pulseEn), .senseEn(senseEn), .busy(busy), .done(done),
      .fail(fail), .readData(readData));
   fpp_prom_model #(.STUCK_WORD(STUCK_W), .STUCK_BIT(STUCK_B)) model_u (
      .clk(clk), .wordSelectLines(wordSelectLines),
      .selectN(selectN), .pulseEn(pulseEn), .senseEn(senseEn),
      .dataLines(dataLines), .senseOk(senseOk));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function stuck(input [4:0] w, input [2:0] b);
      stuck = (w == STUCK_W) && (b == STUCK_B);
   endfunction
   function [7:0] burned(input [4:0] w, input [7:0] old, input [2:0] b);
      burned = stuck(w, b) ? old : (old | (8'h01 << b));
   endfunction
   task summarize;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_fail);
         if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task check(input [7:0] got, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // a stray read is poked mid burn; it must be ignored
   task op(input rd, input [4:0] w, input [2:0] b);
      integer i;
      begin
         readReq = rd;
         burnReq = !rd;
         reqWord = w;
         reqBit = b;
         @(posedge clk) #1;
         burnReq = 1'b0;
         i = 0;
         while (done !== 1'b1 && i < 20000) begin
            readReq = (i == 500);
            @(posedge clk) #1;
            i = i + 1;
         end
         readReq = 1'b0;
         if (i >= 20000) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: no done", $time);
            summarize;
         end
         @(posedge clk) #1;
      end
   endtask
   initial begin
      for (k = 0; k < 32; k = k + 1) shadow[k] = 8'h00;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      check({7'h00, selectN}, 8'h01);
      check(dataLines, 8'hff);
      op(1'b1, 5'h1f, 3'h0);
      check(readData, 8'h00);
      for (k = 0; k < 6; k = k + 1) begin
         seed = xs(seed);
         if (k >= 4)
            seed[7:0] = 8'he0;
         else if (k == 3)
            seed[7:0] = {STUCK_B, STUCK_W}; // fuse that never opens
         op(1'b0, seed[4:0], seed[7:5]);
         shadow[seed[4:0]] = burned(seed[4:0], shadow[seed[4:0]],
            seed[7:5]);
         check({7'h00, fail}, {7'h00, stuck(seed[4:0], seed[7:5])});
         check({7'h00, busy}, 8'h00);
         op(1'b1, seed[4:0], 3'h0);
         check(readData, shadow[seed[4:0]]);
      end
      summarize;
   end
endmodule
